// [core/pcr_cap_regs.v]
// Express capability register bank behind an APB slave port
//
// Functional notes
// - Capability identifier byte is read-only and returns 0x10.
// - Next-capability pointer byte is read-only and returns 0x80.
// - Read-only five-bit interrupt message number sits in capabilities bits 13:9.
// - Port type field encodes application and exposes or hides type-specific bits.
// - Capability version in capabilities bits 3:0 reads 0x2.
// - Device capabilities read-only; bit 28 shows function level reset support.
// - Supported max payload codes 000..101 mean 128..4096 bytes; 110, 111 reserved.
// - Writable max read request size; user reads never exceed it.
// - Writable max payload size; user packets never exceed it.
// - Device control bits 15, 11, 10, 9, 8 and 4 are writable enables.
// - Device control bits 3..0 are writable error reporting enables.
// - Device status bits 15:4 read-only; bits 3:0 clear on written one.
// - Status bits 15:6 zero, 5 pending, 4 aux power, 3:0 errors.
// - Link caps: port number, bit 22 one, bits 21:19 downstream only, 18 zero.
// - Link caps power-state support field and L1, L0s exit latencies.
// - Maximum link width uses one-hot lane codes.
// - Maximum link speed codes 0001, 0010, 0011.
// - Link control writable bits 11:9, 7:4; bits 15:12 and 8 read zero.
// - Link control bit 3 picks completion boundary; bit 2 reads zero.
// - Link control bits 1:0 enable L0s, L1 or both.
// - Link status bits 15:11 report link state; bit 10 reads zero.
// - Link status reports negotiated width one-hot and current speed.
// - Capabilities pointer in the standard header reads 0x40.
`timescale 1ns/100ps
`default_nettype none
`include "pcr_defines.vh"

module pcr_cap_regs
(
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Device configuration
  input  wire [3:0]  cfgPortType,
  input  wire [4:0]  cfgIntMsgNum,
  input  wire        cfgSlotImpl,
  input  wire        cfgFlrSupported,
  input  wire [2:0]  cfgMaxPayloadSup,
  input  wire [1:0]  cfgPhantomSup,
  input  wire        cfgExtTagSup,
  input  wire [2:0]  cfgL0sAccLat,
  input  wire [2:0]  cfgL1AccLat,
  // Link configuration
  input  wire [7:0]  cfgPortNum,
  input  wire [2:0]  cfgL1ExitLat,
  input  wire [2:0]  cfgL0sExitLat,
  input  wire [1:0]  cfgAspmSup,
  input  wire [5:0]  cfgMaxLinkWidth,
  input  wire [3:0]  cfgMaxLinkSpeed,
  // Device events and state
  input  wire        evtUnsupReq,
  input  wire        evtFatalErr,
  input  wire        evtNonFatalErr,
  input  wire        evtCorrErr,
  input  wire        stTransPending,
  input  wire        stAuxPowerDet,
  // Link state
  input  wire        stAutoBwChange,
  input  wire        stBwMgmtChange,
  input  wire        stDllActive,
  input  wire        stSlotClkCfg,
  input  wire        stLinkTraining,
  input  wire [5:0]  stNegWidth,
  input  wire [3:0]  stLinkSpeed,
  // Device control outputs
  output wire [2:0]  ctlMaxReadReqCode,
  output wire [2:0]  ctlMaxPayloadCode,
  output wire [12:0] ctlMaxReadReqBytes,
  output wire [12:0] ctlMaxPayloadBytes,
  output wire        ctlBridgeRetryFlr,
  output wire        ctlNoSnoopEn,
  output wire        ctlAuxPwrEn,
  output wire        ctlPhantomEn,
  output wire        ctlExtTagEn,
  output wire        ctlRelaxedOrdEn,
  output wire [3:0]  ctlErrReportEn,
  // Link control outputs and downstream port flag
  output wire        lnkAutoBwIntEn,
  output wire        lnkBwMgmtIntEn,
  output wire        lnkAutoWidthDis,
  output wire        lnkExtSync,
  output wire        lnkCommonClk,
  output wire        lnkRetrainPulse,
  output wire        lnkDisable,
  output wire        lnkRcb128,
  output wire [1:0]  lnkAspmCtl,
  output wire        isDownstream
);

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // Size code to bytes: each step doubles from 128
  function [12:0] codeToBytes;
    input [2:0] code;
    begin
      codeToBytes = `PCR_SIZE_BASE << code;
    end
  endfunction

  // Merge the two low byte lanes of a write into a 16-bit register
  function [15:0] laneMerge;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0]  strb;
    begin
      laneMerge[7:0]  = strb[0] ? newVal[7:0] : oldVal[7:0];
      laneMerge[15:8] = strb[1] ? newVal[15:8] : oldVal[15:8];
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------------
  wire [9:0]  regIdx;
  wire        aligned;
  wire        setupRead;
  wire        setupAny;
  wire        accessWrite;

  pcr_apb_slave u_apb
  (
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .regIdx      (regIdx),
    .aligned     (aligned),
    .setupRead   (setupRead),
    .setupAny    (setupAny),
    .accessWrite (accessWrite),
    .pready      (pready)
  );

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  reg  [15:0] devCtrl_q;
  reg  [15:0] devCtrl_d;
  reg  [15:0] linkCtrl_q;
  reg  [15:0] linkCtrl_d;
  reg  [3:0]  errStat_q;
  reg  [3:0]  errStat_d;
  reg         retrain_q;
  reg  [31:0] rdData_q;
  reg         slvErr_q;
  reg  [31:0] rdMux;
  reg         hit;

  wire        wrDevCtrl  = accessWrite & aligned & (regIdx == `PCR_IDX_DEV_CTRL);
  wire        wrDevStat  = accessWrite & aligned & (regIdx == `PCR_IDX_DEV_STAT);
  wire        wrLinkCtrl = accessWrite & aligned & (regIdx == `PCR_IDX_LINK_CTRL);
  wire [15:0] wrDataLo   = pwdata[15:0];

  // ----------------------------------------------------------------------------
  // Hard-wired words
  // ----------------------------------------------------------------------------
  wire        downstream = (cfgPortType == `PCR_TYPE_ROOT_PORT) ||
                           (cfgPortType == `PCR_TYPE_SWITCH_DOWN);

  wire [15:0] expCaps = {2'h0,
                         cfgIntMsgNum,
                         cfgSlotImpl & downstream,
                         cfgPortType,
                         `PCR_VAL_CAP_VERSION};

  wire [31:0] devCaps = {3'h0,
                         cfgFlrSupported,
                         12'h000,
                         4'h0,
                         cfgL1AccLat,
                         cfgL0sAccLat,
                         cfgExtTagSup,
                         cfgPhantomSup,
                         cfgMaxPayloadSup};

  wire [31:0] linkCaps = {cfgPortNum,
                          1'b0,
                          1'b1,
                          {3{downstream}},
                          1'b0,
                          cfgL1ExitLat,
                          cfgL0sExitLat,
                          cfgAspmSup,
                          cfgMaxLinkWidth,
                          cfgMaxLinkSpeed};

  wire [15:0] devStat = {10'h000,
                         stTransPending,
                         stAuxPowerDet,
                         errStat_q};

  wire [15:0] linkStat = {stAutoBwChange,
                          stBwMgmtChange,
                          stDllActive,
                          stSlotClkCfg,
                          stLinkTraining,
                          1'b0,
                          stNegWidth,
                          stLinkSpeed};

  // ----------------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------------
  always @*
  begin
    hit   = aligned;
    rdMux = 32'h0000_0000;
    case (regIdx)
      `PCR_IDX_CAP_PTR   : rdMux = {24'h000000, `PCR_VAL_CAP_PTR};
      `PCR_IDX_CAP_ID    : rdMux = {24'h000000, `PCR_VAL_CAP_ID};
      `PCR_IDX_NEXT_PTR  : rdMux = {24'h000000, `PCR_VAL_NEXT_PTR};
      `PCR_IDX_EXP_CAPS  : rdMux = {16'h0000, expCaps};
      `PCR_IDX_DEV_CAPS  : rdMux = devCaps;
      `PCR_IDX_DEV_CTRL  : rdMux = {16'h0000, devCtrl_q};
      `PCR_IDX_DEV_STAT  : rdMux = {16'h0000, devStat};
      `PCR_IDX_LINK_CAPS : rdMux = linkCaps;
      `PCR_IDX_LINK_CTRL : rdMux = {16'h0000, linkCtrl_q};
      `PCR_IDX_LINK_STAT : rdMux = {16'h0000, linkStat};
      default            : hit = 1'b0;
    endcase
    if (!aligned)
    begin
      rdMux = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // Next values of writable state
  // ----------------------------------------------------------------------------
  reg  [15:0] dcMerged;
  reg  [2:0]  newMrrs;
  reg  [2:0]  newMps;

  always @*
  begin
    dcMerged  = laneMerge(devCtrl_q, wrDataLo, pstrb[1:0]);
    newMrrs   = dcMerged[`PCR_DC_MRRS_LSB +: 3];
    newMps    = dcMerged[`PCR_DC_MPS_LSB +: 3];
    devCtrl_d = devCtrl_q;
    if (wrDevCtrl)
    begin
      // Only writable bits change; others stay fixed
      devCtrl_d = (dcMerged & `PCR_DC_WR_MASK) | (devCtrl_q & ~`PCR_DC_WR_MASK);
      // A reserved size code would leave user logic without a limit, so it is refused
      if (newMrrs > `PCR_SIZE_CODE_MAX)
      begin
        devCtrl_d[`PCR_DC_MRRS_LSB +: 3] = devCtrl_q[`PCR_DC_MRRS_LSB +: 3];
      end
      if (newMps > `PCR_SIZE_CODE_MAX)
      begin
        devCtrl_d[`PCR_DC_MPS_LSB +: 3] = devCtrl_q[`PCR_DC_MPS_LSB +: 3];
      end
    end
  end

  always @*
  begin
    linkCtrl_d = linkCtrl_q;
    if (wrLinkCtrl)
    begin
      linkCtrl_d = laneMerge(linkCtrl_q, wrDataLo, pstrb[1:0]) & `PCR_LC_WR_MASK;
    end
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always @*
  begin
    errStat_d = errStat_q;
    if (wrDevStat && pstrb[0])
    begin
      errStat_d = errStat_q & ~(wrDataLo[3:0] & `PCR_DS_W1C_MASK);
    end
    errStat_d = errStat_d | {evtUnsupReq, evtFatalErr, evtNonFatalErr, evtCorrErr};
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      devCtrl_q  <= `PCR_RST_DEV_CTRL;
      linkCtrl_q <= `PCR_RST_LINK_CTRL;
      errStat_q  <= 4'h0;
      retrain_q  <= 1'b0;
      rdData_q   <= 32'h0000_0000;
      slvErr_q   <= 1'b0;
    end
    else
    begin
      devCtrl_q  <= devCtrl_d;
      linkCtrl_q <= linkCtrl_d;
      errStat_q  <= errStat_d;
      retrain_q  <= wrLinkCtrl & pstrb[0] & wrDataLo[`PCR_LC_RETRAIN];
      if (setupRead)
      begin
        rdData_q <= rdMux;
      end
      if (setupAny)
      begin
        slvErr_q <= ~hit;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign prdata  = rdData_q;
  assign pslverr = slvErr_q & psel & penable;

  assign ctlMaxReadReqCode  = devCtrl_q[14:12];
  assign ctlMaxPayloadCode  = devCtrl_q[7:5];
  assign ctlMaxReadReqBytes = codeToBytes(devCtrl_q[14:12]);
  assign ctlMaxPayloadBytes = codeToBytes(devCtrl_q[7:5]);
  assign ctlBridgeRetryFlr  = devCtrl_q[15];
  assign ctlNoSnoopEn       = devCtrl_q[11];
  assign ctlAuxPwrEn        = devCtrl_q[10];
  assign ctlPhantomEn       = devCtrl_q[9];
  assign ctlExtTagEn        = devCtrl_q[8];
  assign ctlRelaxedOrdEn    = devCtrl_q[4];
  assign ctlErrReportEn     = devCtrl_q[3:0];

  assign lnkAutoBwIntEn  = linkCtrl_q[11];
  assign lnkBwMgmtIntEn  = linkCtrl_q[10];
  assign lnkAutoWidthDis = linkCtrl_q[9];
  assign lnkExtSync      = linkCtrl_q[7];
  assign lnkCommonClk    = linkCtrl_q[6];
  assign lnkRetrainPulse = retrain_q;
  assign lnkDisable      = linkCtrl_q[4];
  assign lnkRcb128       = linkCtrl_q[3];
  assign lnkAspmCtl      = linkCtrl_q[1:0];
  assign isDownstream    = downstream;

endmodule

`default_nettype wire

// [core/pcr_defines.vh]
// Constants of the express capability register bank: indexes, field positions, reset values
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indexes (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PCR_IDX_CAP_PTR        10'h034
`define PCR_IDX_CAP_ID         10'h040
`define PCR_IDX_NEXT_PTR       10'h041
`define PCR_IDX_EXP_CAPS       10'h042
`define PCR_IDX_DEV_CAPS       10'h044
`define PCR_IDX_DEV_CTRL       10'h048
`define PCR_IDX_DEV_STAT       10'h04a
`define PCR_IDX_LINK_CAPS      10'h04c
`define PCR_IDX_LINK_CTRL      10'h050
`define PCR_IDX_LINK_STAT      10'h052

// ----------------------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------------------
`define PCR_VAL_CAP_PTR        8'h40
`define PCR_VAL_CAP_ID         8'h10
`define PCR_VAL_NEXT_PTR       8'h80
`define PCR_VAL_CAP_VERSION    4'h2
`define PCR_TYPE_ROOT_PORT     4'h4
`define PCR_TYPE_SWITCH_DOWN   4'h6
`define PCR_SIZE_BASE          13'h0080
`define PCR_SIZE_CODE_MAX      3'h5

// ----------------------------------------------------------------------------
// Reset values of the writable registers
// ----------------------------------------------------------------------------
`define PCR_RST_DEV_CTRL       16'h2000
`define PCR_RST_LINK_CTRL      16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PCR_DC_MRRS_LSB        12
`define PCR_DC_MPS_LSB         5
`define PCR_DC_WR_MASK         16'hffff
`define PCR_LC_WR_MASK         16'h0efb
`define PCR_LC_RETRAIN         5
`define PCR_DS_W1C_MASK        4'hf

`endif

// [core/pcr_apb_slave.v]
// APB slave front end: index decode, access strobes and ready
`timescale 1ns/100ps
`default_nettype none

module pcr_apb_slave
(
  // APB request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  // Decoded access
  output wire [9:0]  regIdx,
  output wire        aligned,
  output wire        setupRead,
  output wire        setupAny,
  output wire        accessWrite,
  output wire        pready
);

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  // Zero wait states: read data is latched in the setup phase, so ready can stay high
  assign regIdx      = paddr[11:2];
  assign aligned     = (paddr[1:0] == 2'h0);
  assign setupAny    = psel & ~penable;
  assign setupRead   = setupAny & ~pwrite;
  assign accessWrite = psel & penable & pwrite;
  assign pready      = 1'b1;

endmodule

`default_nettype wire

// [testbench/pcr_cap_regs_monitor.sv]
// Assertion checker for the capability register bank
`timescale 1ns/100ps
`default_nettype none
module pcr_cap_regs_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Configuration and controls
  input wire logic [3:0]  cfgPortType,
  input wire logic [2:0]  ctlMaxReadReqCode,
  input wire logic [2:0]  ctlMaxPayloadCode,
  input wire logic [12:0] ctlMaxReadReqBytes,
  input wire logic [12:0] ctlMaxPayloadBytes,
  input wire logic [3:0]  ctlErrReportEn,
  input wire logic        lnkRetrainPulse,
  input wire logic        isDownstream
);
  // ------
  // Sequences and helpers
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic rtWr_q;
  sequence acc_wr;
    psel && penable && pwrite;
  endsequence
  sequence rd_setup(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence bad_setup;
    psel && !penable && paddr[1:0] != 2'h0;
  endsequence
  sequence retrain_wr;
    acc_wr ##0 (paddr == 12'h140 && pstrb[0] && pwdata[5]);
  endsequence
  // Remembers a retrain write so a pulse without cause is caught
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      rtWr_q <= 1'b0;
    else
      rtWr_q <= psel && penable && pwrite && paddr == 12'h140 && pstrb[0] && pwdata[5];
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_misalign_err: assert property (bad_setup ##1 (psel && penable) |-> pslverr)
    else $error("misaligned access without error response");
  a_retrain_pulse: assert property (retrain_wr |=> lnkRetrainPulse)
    else $error("retrain write gave no pulse");
  a_pulse_cause: assert property (lnkRetrainPulse |-> rtWr_q)
    else $error("retrain pulse without write");
  a_mrrs_bytes: assert property (ctlMaxReadReqBytes == (13'h80 << ctlMaxReadReqCode))
    else $error("read request bytes wrong");
  a_mps_bytes: assert property (ctlMaxPayloadBytes == (13'h80 << ctlMaxPayloadCode))
    else $error("payload bytes wrong");
  a_size_legal: assert property (ctlMaxReadReqCode <= 3'h5 && ctlMaxPayloadCode <= 3'h5)
    else $error("reserved size code held");
  a_type_down: assert property (isDownstream == (cfgPortType == 4'h4 || cfgPortType == 4'h6))
    else $error("downstream flag wrong");
  a_enable_hold: assert property (!(psel && penable && pwrite) |=> $stable(ctlErrReportEn))
    else $error("report enables moved without write");
  a_capid_read: assert property (rd_setup(12'h100) ##1 penable |-> prdata == 32'h10)
    else $error("capability id wrong");
  a_next_read: assert property (rd_setup(12'h104) ##1 penable |-> prdata == 32'h80)
    else $error("next pointer wrong");
endmodule
bind pcr_cap_regs pcr_cap_regs_monitor mon_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pslverr, .cfgPortType, .ctlMaxReadReqCode, .ctlMaxPayloadCode, .ctlMaxReadReqBytes,
  .ctlMaxPayloadBytes, .ctlErrReportEn, .lnkRetrainPulse, .isDownstream);
`default_nettype wire

// [testbench/pcr_apb_master.sv]
// Configuration software model: APB master for register accesses
`timescale 1ns/100ps
`default_nettype none
module pcr_apb_master
(
  // Clock
  input  wire logic        clk,
  // APB
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Status
  output logic             tmo
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, tmo} = '0;
  end
  // Entered just after a rising edge; an idle edge follows so calls never collide
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      tmo = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [testbench/pcr_cap_regs_test.sv]
// Self-checking bench for the capability register bank
`timescale 1ns/100ps
`default_nettype none
module pcr_cap_regs_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, tmo, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w, s;
  logic [3:0] pstrb, stat;
  logic [3:0] ev = 4'h0;
  logic [65:0] rv = '0;
  logic [15:0] dc, lc;
  logic [2:0] ctlMaxReadReqCode, ctlMaxPayloadCode;
  logic [12:0] ctlMaxReadReqBytes, ctlMaxPayloadBytes;
  logic ctlBridgeRetryFlr, ctlNoSnoopEn, ctlAuxPwrEn, ctlPhantomEn, ctlExtTagEn, ctlRelaxedOrdEn;
  logic [3:0] ctlErrReportEn;
  logic lnkAutoBwIntEn, lnkBwMgmtIntEn, lnkAutoWidthDis, lnkExtSync, lnkCommonClk, lnkDisable, lnkRcb128;
  logic [1:0] lnkAspmCtl;
  logic [11:0] fa [3] = '{12'h0d0, 12'h100, 12'h104};
  logic [31:0] fv [3] = '{32'h40, 32'h10, 32'h80};
  int error_cnt = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  pcr_apb_master mst_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .tmo);
  pcr_cap_regs dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cfgPortType(rv[3:0]), .cfgIntMsgNum(rv[8:4]), .cfgSlotImpl(rv[9]),
    .cfgFlrSupported(rv[10]), .cfgMaxPayloadSup(rv[13:11]), .cfgPhantomSup(rv[15:14]),
    .cfgExtTagSup(rv[16]), .cfgL0sAccLat(rv[19:17]), .cfgL1AccLat(rv[22:20]), .cfgPortNum(rv[30:23]),
    .cfgL1ExitLat(rv[33:31]), .cfgL0sExitLat(rv[36:34]), .cfgAspmSup(rv[38:37]),
    .cfgMaxLinkWidth(rv[44:39]), .cfgMaxLinkSpeed(rv[48:45]), .evtUnsupReq(ev[3]),
    .evtFatalErr(ev[2]), .evtNonFatalErr(ev[1]), .evtCorrErr(ev[0]), .stTransPending(rv[49]),
    .stAuxPowerDet(rv[50]), .stAutoBwChange(rv[51]), .stBwMgmtChange(rv[52]), .stDllActive(rv[53]),
    .stSlotClkCfg(rv[54]), .stLinkTraining(rv[55]), .stNegWidth(rv[61:56]), .stLinkSpeed(rv[65:62]),
    .ctlMaxReadReqCode, .ctlMaxPayloadCode, .ctlMaxReadReqBytes, .ctlMaxPayloadBytes,
    .ctlBridgeRetryFlr, .ctlNoSnoopEn, .ctlAuxPwrEn, .ctlPhantomEn, .ctlExtTagEn, .ctlRelaxedOrdEn,
    .ctlErrReportEn, .lnkAutoBwIntEn, .lnkBwMgmtIntEn, .lnkAutoWidthDis, .lnkExtSync, .lnkCommonClk,
    .lnkRetrainPulse(), .lnkDisable, .lnkRcb128, .lnkAspmCtl, .isDownstream());
  // ------
  // Expected values
  // ------
  function automatic logic ds();
    return rv[3:0] == 4'h4 || rv[3:0] == 4'h6;
  endfunction
  function automatic logic [15:0] wrM(input logic [15:0] o, n, m, input logic [1:0] b);
    logic [15:0] k;
    k = m & {{8{b[1]}}, {8{b[0]}}};
    return (o & ~k) | (n & k);
  endfunction
  // Reserved size codes leave the old field in place
  function automatic logic [15:0] devWr(input logic [15:0] o, n, input logic [1:0] b);
    logic [15:0] v;
    v = wrM(o, n, 16'hffff, b);
    if (v[14:12] > 3'h5)
      v[14:12] = o[14:12];
    if (v[7:5] > 3'h5)
      v[7:5] = o[7:5];
    return v;
  endfunction
  // ------
  // Tasks
  // ------
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    mst_u.xfer(wr, a, d, b, rd, er);
    if (tmo)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(32'h40ff));
    stat = 4'h0;
    dc = 16'h2000;
    lc = 16'h0000;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (fa[i])
    begin
      acc(1'b1, fa[i], 32'hffffffff, 4'hf);
      acc(1'b0, fa[i], 32'h0, 4'h0);
      chk(rd, fv[i]);
    end
    acc(1'b0, 12'h200, 32'h0, 4'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    acc(1'b1, 12'h121, 32'hffffffff, 4'hf);
    chk({31'h0, er}, 32'h1);
    repeat (24)
    begin
      rv <= 66'({$urandom(), $urandom(), $urandom()});
      ev <= 4'($urandom());
      @(posedge clk);
      ev <= 4'h0;
      stat = stat | ev;
      acc(1'b0, 12'h108, 32'h0, 4'h0);
      chk(rd, {18'h0, rv[8:4], rv[9] & ds(), rv[3:0], 4'h2});
      acc(1'b0, 12'h110, 32'h0, 4'h0);
      chk(rd, {3'h0, rv[10], 16'h0, rv[22:20], rv[19:17], rv[16], rv[15:14], rv[13:11]});
      acc(1'b0, 12'h130, 32'h0, 4'h0);
      chk(rd, {rv[30:23], 2'b01, {3{ds()}}, 1'b0, rv[33:31], rv[36:34], rv[38:37], rv[44:39], rv[48:45]});
      acc(1'b0, 12'h148, 32'h0, 4'h0);
      chk(rd, {16'h0, rv[51], rv[52], rv[53], rv[54], rv[55], 1'b0, rv[61:56], rv[65:62]});
      acc(1'b0, 12'h128, 32'h0, 4'h0);
      chk(rd, {26'h0, rv[49], rv[50], stat});
      acc(1'b0, 12'h120, 32'h0, 4'h0);
      chk(rd, {16'h0, dc});
      acc(1'b0, 12'h140, 32'h0, 4'h0);
      chk(rd, {16'h0, lc});
      chk({19'h0, ctlMaxReadReqBytes}, 32'h80 << dc[14:12]);
      chk({19'h0, ctlMaxPayloadBytes}, 32'h80 << dc[7:5]);
      chk({ctlBridgeRetryFlr, ctlMaxReadReqCode, ctlNoSnoopEn, ctlAuxPwrEn, ctlPhantomEn, ctlExtTagEn,
        ctlMaxPayloadCode, ctlRelaxedOrdEn, ctlErrReportEn}, {16'h0, dc});
      chk({lnkAutoBwIntEn, lnkBwMgmtIntEn, lnkAutoWidthDis, 1'b0, lnkExtSync, lnkCommonClk, lc[5],
        lnkDisable, lnkRcb128, 1'b0, lnkAspmCtl}, {16'h0, lc});
      w = $urandom();
      s = $urandom();
      acc(1'b1, 12'h128, w, s[3:0]);
      if (s[0])
        stat = stat & ~w[3:0];
      acc(1'b1, 12'h120, w, s[3:0]);
      dc = devWr(dc, w[15:0], s[1:0]);
      acc(1'b1, 12'h140, w, s[3:0]);
      lc = wrM(lc, w[15:0], 16'h0efb, s[1:0]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
